// [src/sts_pkg.sv]
// ==========================================================
// Timing constants for the bus timing supervisor
// ==========================================================
package sts_pkg;
  // Core clock rate
  localparam int CLK_HZ        = 50_000_000;
  // Master clock rate in tenths of kHz (51.2 kHz)
  localparam int MAS_KHZ_X10   = 512;
  localparam int MAS_HALF_CYC  = (CLK_HZ * 10) / (MAS_KHZ_X10 * 1000 * 2);
  // Clock-low timeout, chosen inside the 25..35 ms window
  localparam int TIMEOUT_MS    = 30;
  localparam int TIMEOUT_CYC   = (CLK_HZ / 1000) * TIMEOUT_MS;
  // Longest clock-high time while a message is open
  localparam int HIGH_MAX_US   = 50;
  localparam int HIGH_MAX_CYC  = (CLK_HZ / 1_000_000) * HIGH_MAX_US;
  // Cumulative stretch budgets per message
  localparam int SEXT_MS       = 25;
  localparam int SEXT_CYC      = (CLK_HZ / 1000) * SEXT_MS;
  localparam int MEXT_MS       = 10;
  localparam int MEXT_CYC      = (CLK_HZ / 1000) * MEXT_MS;
  // Counter widths
  localparam int LONG_W        = 22;
  localparam int SHORT_W       = 12;
  // Bus state machine, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_MSG   = 3'b010,
    ST_ABORT = 3'b100
  } sts_state_t;
endpackage

// [src/sts_supervisor.sv]
`timescale 1ns/1ns
// Behaviour
// - Own master clock runs near 51.2 kHz
// - Clock low beyond limit flags timeout
// - Clock high over 50 us aborts message
// - Slave stretching per message capped 25 ms
// - Master extension per message capped 10 ms
module sts_supervisor #(
  parameter int TIMEOUT_LIM = sts_pkg::TIMEOUT_CYC,
  parameter int SEXT_LIM    = sts_pkg::SEXT_CYC,
  parameter int MEXT_LIM    = sts_pkg::MEXT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bus clock pin, open drain
  input  wire logic bus_clock_line_i,
  output logic      bus_clock_line_o,
  output logic      bus_clock_line_oe,
  // Bus data pin, open drain
  input  wire logic bus_data_line_i,
  output logic      bus_data_line_o,
  output logic      bus_data_line_oe,
  // Requests from the protocol engine
  input  wire logic master_en,
  input  wire logic slv_hold_req,
  input  wire logic mst_hold_req,
  input  wire logic data_low_req,
  // Status towards the protocol engine
  output logic      msg_active,
  output logic      timeout_err,
  output logic      idle_abort,
  output logic      sext_spent,
  output logic      mext_spent
);
  import sts_pkg::*;

  // ========================================================
  // Input synchronisers
  // ========================================================
  logic [2:0]           scl_sync_ff;   // Clock pin samples
  logic [2:0]           sda_sync_ff;   // Data pin samples
  logic                 scl_ff;        // Filtered clock level
  logic                 sda_ff;        // Filtered data level

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff      <= 1'b1;
      sda_ff      <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], bus_clock_line_i};
      sda_sync_ff <= {sda_sync_ff[1:0], bus_data_line_i};
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_ff <= sda_sync_ff[2];
      end
    end
  end

  // ========================================================
  // Condition decode
  // ========================================================
  wire scl_new = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_ff;
  wire sda_new = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
  // Start: data falls while clock high
  wire start_det = scl_ff & scl_new & sda_ff & ~sda_new;
  // Stop: data rises while clock high
  wire stop_det  = scl_ff & scl_new & ~sda_ff & sda_new;

  // ========================================================
  // State and counters
  // ========================================================
  sts_state_t           state_ff;      // Bus state
  sts_state_t           nxt_state;     // Next bus state
  logic [LONG_W-1:0]    low_cnt_ff;    // Current clock-low length
  logic [SHORT_W-1:0]   high_cnt_ff;   // Current clock-high length
  logic [LONG_W-1:0]    sext_cnt_ff;   // Slave stretch used
  logic [LONG_W-1:0]    mext_cnt_ff;   // Master extension used
  logic [SHORT_W-1:0]   div_cnt_ff;    // Master clock divider
  logic                 mclk_low_ff;   // Own master clock phase
  logic                 scl_hold_ff;   // Drive clock low
  logic                 sda_hold_ff;   // Drive data low

  // Limit checks
  wire in_msg      = (state_ff == ST_MSG);
  wire timeout_hit = ~scl_ff & (low_cnt_ff >= LONG_W'(TIMEOUT_LIM));
  wire high_hit    = in_msg & scl_ff &
                     (high_cnt_ff >= SHORT_W'(HIGH_MAX_CYC));
  wire abort_now   = in_msg & (timeout_hit | high_hit);
  wire sext_left   = sext_cnt_ff < LONG_W'(SEXT_LIM);
  // Room left for one more extended half-period of the own clock
  wire mext_left   = (mext_cnt_ff + LONG_W'(MAS_HALF_CYC)) <=
                     LONG_W'(MEXT_LIM);
  // Half-period tick of own master clock
  wire div_tick    = (div_cnt_ff == SHORT_W'(MAS_HALF_CYC - 1));
  // Slave stretch only with a remote master driving the clock
  wire slv_stretch = in_msg & ~master_en & ~scl_ff & slv_hold_req &
                     sext_left;
  // Master extension holds own low phase past its tick
  wire mst_stretch = in_msg & master_en & mclk_low_ff & mst_hold_req &
                     mext_left;
  // Own clock phase toggles on tick unless extended
  wire mclk_flip   = in_msg & master_en & div_tick & ~mst_stretch;

  // Next state decode
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_det) begin
          nxt_state = ST_MSG;
        end
      end
      ST_MSG: begin
        if (abort_now) begin
          nxt_state = ST_ABORT;
        end else if (stop_det) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ABORT: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Clock-low counter restarts at the timeout; clock-high counter saturates
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_ff  <= '0;
      high_cnt_ff <= '0;
    end else begin
      if (scl_ff || timeout_hit) begin
        low_cnt_ff <= '0;
      end else begin
        low_cnt_ff <= low_cnt_ff + LONG_W'(1);
      end
      if (!scl_ff || !in_msg) begin
        high_cnt_ff <= '0;
      end else if (!high_hit) begin
        high_cnt_ff <= high_cnt_ff + SHORT_W'(1);
      end
    end
  end

  // Per-message stretch budgets, cleared while no message is open
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sext_cnt_ff <= '0;
      mext_cnt_ff <= '0;
    end else if (!in_msg) begin
      sext_cnt_ff <= '0;
      mext_cnt_ff <= '0;
    end else begin
      if (slv_stretch) begin
        sext_cnt_ff <= sext_cnt_ff + LONG_W'(1);
      end
      if (mst_stretch && div_tick) begin
        // Budget is kept in cycles: one extended tick spends a half-period
        mext_cnt_ff <= mext_cnt_ff + LONG_W'(MAS_HALF_CYC);
      end
    end
  end

  // Master clock divider and phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff  <= '0;
      mclk_low_ff <= 1'b0;
    end else if (!in_msg || !master_en) begin
      div_cnt_ff  <= '0;
      mclk_low_ff <= 1'b0;
    end else begin
      div_cnt_ff <= div_tick ? '0 : div_cnt_ff + SHORT_W'(1);
      if (mclk_flip) begin
        mclk_low_ff <= ~mclk_low_ff;
      end
    end
  end

  // ========================================================
  // Pin drivers and status flops
  // ========================================================
  // Both lines released during an abort; after it the data line follows data_low_req
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_hold_ff <= 1'b0;
      sda_hold_ff <= 1'b0;
    end else if (abort_now || !in_msg) begin
      scl_hold_ff <= 1'b0;
      sda_hold_ff <= in_msg ? 1'b0 : data_low_req & ~abort_now;
    end else begin
      scl_hold_ff <= slv_stretch | (master_en & mclk_low_ff);
      sda_hold_ff <= data_low_req;
    end
  end

  // Event pulses and levels for the protocol engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_err <= 1'b0;
      idle_abort  <= 1'b0;
      sext_spent  <= 1'b0;
      mext_spent  <= 1'b0;
      msg_active  <= 1'b0;
    end else begin
      timeout_err <= timeout_hit;
      idle_abort  <= high_hit;
      sext_spent  <= in_msg & ~sext_left;
      mext_spent  <= in_msg & ~mext_left;
      msg_active  <= (nxt_state == ST_MSG);
    end
  end

  // Open-drain lines only ever pull low
  assign bus_clock_line_o  = 1'b0;
  assign bus_data_line_o   = 1'b0;
  assign bus_clock_line_oe = scl_hold_ff;
  assign bus_data_line_oe  = sda_hold_ff;

endmodule // sts_supervisor

// [verif/sts_chk.sv]
`timescale 1ns/1ns
// ==========
// Port checks, bound to the supervisor
module sts_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin enables, mode and status
  input wire logic bus_clock_line_oe,
  input wire logic bus_data_line_oe,
  input wire logic master_en,
  input wire logic msg_active,
  input wire logic timeout_err,
  input wire logic idle_abort,
  input wire logic sext_spent,
  input wire logic mext_spent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_tmo; timeout_err |=> !timeout_err; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout flag too long");
  property p_tmo_rel; timeout_err |-> ##[0:3] !bus_data_line_oe; endproperty
  a_tmo_rel: assert property (p_tmo_rel) else $error("data kept");
  property p_idle; idle_abort |=> !idle_abort; endproperty
  a_idle: assert property (p_idle) else $error("abort flag too long");
  property p_idle_rel; idle_abort |-> !(msg_active | bus_clock_line_oe);
  endproperty
  a_idle_rel: assert property (p_idle_rel) else $error("abort open");
  property p_clr; $fell(msg_active) |-> ##[0:2] !(sext_spent | mext_spent);
  endproperty
  a_clr: assert property (p_clr) else $error("budget kept");
  property p_mclk; master_en && $changed(bus_clock_line_oe) |=>
    $stable(bus_clock_line_oe)[*8]; endproperty
  a_mclk: assert property (p_mclk) else $error("clock phase short");
  property p_tmo_abort; timeout_err |-> !msg_active; endproperty
  a_tmo_abort: assert property (p_tmo_abort) else $error("msg on");
  property p_sext; sext_spent && !master_en |=> !bus_clock_line_oe;
  endproperty
  a_sext: assert property (p_sext) else $error("stretch kept");
  c_tmo: cover property (timeout_err);
  c_idle: cover property (idle_abort);
  c_mext: cover property (mext_spent && msg_active);
  c_sext: cover property (sext_spent && msg_active);
endmodule // sts_chk
bind sts_supervisor sts_chk u_sts_chk (.*);

// [verif/sts_host.sv]
`timescale 1ns/1ns
// ==========
// Far-side host: open-drain pulls, high pulls low
module sts_host (
  // Pulls, both released at power-up
  output logic scl_pull = 1'b0,
  output logic sda_pull = 1'b0
);
  // Half period of the remote clock, 100 kHz at the top of its range
  localparam int HALF_NS = 5000;
  task automatic clk_bits(input int nb);
    repeat (nb) begin
      #HALF_NS scl_pull = 1'b0;
      #HALF_NS scl_pull = 1'b1;
    end
  endtask
  task automatic start_msg(); // Data falls while clock high
    sda_pull = 1'b1;
    #80 scl_pull = 1'b1;
  endtask
  task automatic rel_clk(); // Clock let go 80 ns on
    #80 scl_pull = 1'b0;
  endtask
  task automatic stop_msg(); // Data rises while clock high
    rel_clk();
    #80 sda_pull = 1'b0;
  endtask
endmodule // sts_host

// [verif/smbus_timing_supervisor_test.sv]
`timescale 1ns/1ns
// ==========
// Self-checking bench for the timing supervisor
module smbus_timing_supervisor_test;
  import sts_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, master_en = 1'b0, mst_hold_req = 1'b0;
  logic slv_hold_req = 1'b0, data_low_req = 1'b0;
  logic scl_oe, sda_oe, msg_active, timeout_err, idle_abort, mext_spent;
  logic sext_spent, scl_o, sda_o;
  int   num_errors = 0, checked = 0, n;
  wire  scl = !(scl_oe | u_sts_host.scl_pull); // Pull-up, low if pulled
  wire  sda = !(sda_oe | u_sts_host.sda_pull); // Pull-up, low if pulled
  always #10 clk = ~clk;
  sts_host u_sts_host (.scl_pull(), .sda_pull());
  sts_supervisor #(.TIMEOUT_LIM(5000), .SEXT_LIM(300),
    .MEXT_LIM(3 * MAS_HALF_CYC))
    u_sts_supervisor (.clk, .rst_n, .bus_clock_line_i(scl),
    .bus_clock_line_o(scl_o), .bus_clock_line_oe(scl_oe),
    .bus_data_line_i(sda), .bus_data_line_o(sda_o),
    .bus_data_line_oe(sda_oe), .master_en, .slv_hold_req, .mst_hold_req,
    .data_low_req, .msg_active, .timeout_err, .idle_abort, .sext_spent,
    .mext_spent);
  task automatic stp(input int c); // Edges, then 1 ns past the last
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) num_errors++;
    if (seen !== exp) $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_abort(); // Clock low too long, then high too long
    stp(10);
    u_sts_host.start_msg();
    for (n = 0; n < 6000 && timeout_err !== 1'b1; n++) stp(1);
    chk(timeout_err, 1'b1);
    stp(3);
    chk({msg_active, scl_oe, sda_oe}, 3'b000);
    u_sts_host.stop_msg();
    stp(10);
    u_sts_host.start_msg();
    u_sts_host.rel_clk();
    data_low_req = 1'b1;
    chk(msg_active, 1'b1);
    for (n = 0; n < 3000 && idle_abort !== 1'b1; n++) stp(1);
    chk({idle_abort, msg_active, scl_oe, sda_oe}, 4'b1000);
    data_low_req = 1'b0;
    u_sts_host.stop_msg();
  endtask
  task automatic t_master(); // Own clock rate, then extension budget
    stp(10);
    u_sts_host.start_msg();
    master_en = 1'b1;
    u_sts_host.rel_clk();
    for (n = 0; n < 999 && scl_oe !== 1'b0; n++) stp(1);
    for (n = 0; n < 999 && scl_oe !== 1'b1; n++) stp(1);
    for (n = 0; n < 999 && scl_oe === 1'b1; n++) stp(1);
    chk(n, MAS_HALF_CYC);
    mst_hold_req = 1'b1;
    for (n = 0; n < 4000 && mext_spent !== 1'b1; n++) stp(1);
    chk({mext_spent, msg_active}, 2'b11);
    for (n = 0; n < 600 && scl_oe === 1'b1; n++) stp(1);
    chk(scl_oe, 1'b0);
    mst_hold_req = 1'b0;
    stp(20);
    master_en = 1'b0;
    u_sts_host.stop_msg();
  endtask
  task automatic t_slave(); // Remote master bits, then slave stretch
    stp(10);
    u_sts_host.start_msg();
    u_sts_host.clk_bits(3);
    chk({msg_active, scl_oe, sext_spent}, 3'b100);
    slv_hold_req = 1'b1;
    stp(6);
    chk(scl_oe, 1'b1);
    u_sts_host.rel_clk();
    for (n = 0; n < 400 && sext_spent !== 1'b1; n++) stp(1);
    chk({sext_spent, msg_active, scl_oe}, 3'b110);
    slv_hold_req = 1'b0;
    u_sts_host.stop_msg();
    stp(6);
    chk({msg_active, sext_spent}, 2'b00);
  endtask
  task automatic t_reset(); // Reset inside a message, then wait for start
    stp(10);
    u_sts_host.start_msg();
    data_low_req = 1'b1;
    stp(4);
    chk({msg_active, sda_oe}, 2'b11);
    rst_n = 1'b0;
    stp(2);
    chk({msg_active, scl_oe, sda_oe, timeout_err, idle_abort}, 5'h00);
    chk({sext_spent, mext_spent, scl_o, sda_o}, 4'h0);
    data_low_req = 1'b0;
    rst_n = 1'b1;
    stp(6);
    chk({msg_active, sda_oe}, 2'b00);
    u_sts_host.stop_msg();
    stp(10);
  endtask
  initial begin
    stp(4);
    rst_n = 1'b1;
    t_abort();
    t_master();
    t_slave();
    t_reset();
    final_report();
  end
  initial begin // Cycle ceiling against a hang
    repeat (30000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule // smbus_timing_supervisor_test
